// ### pkg/mprs_defines.svh
// Timing constants for the power-up and restart sequencer.
`ifndef MPRS_DEFINES_SVH
`define MPRS_DEFINES_SVH

// Core clock rate in Hz.
`define MPRS_CLK_HZ 25000000
// Supply rise time beyond which startup is held back, in ms.
`define MPRS_SLOW_RISE_MS 12
`define MPRS_SLOW_RISE_CYC ((`MPRS_SLOW_RISE_MS * `MPRS_CLK_HZ) / 1000)
// Extra startup delay after a slow supply rise, in ms.
`define MPRS_SLOW_DELAY_MS 1000
`define MPRS_SLOW_DELAY_CYC ((`MPRS_SLOW_DELAY_MS * `MPRS_CLK_HZ) / 1000)
// Length of the forced brief on/off cycle, in ms.
`define MPRS_BLIP_MS 120
`define MPRS_BLIP_CYC ((`MPRS_BLIP_MS * `MPRS_CLK_HZ) / 1000)
// Minimum low width of the emergency reset input, in ms.
`define MPRS_ERST_MS 10
`define MPRS_ERST_CYC (((`MPRS_ERST_MS * `MPRS_CLK_HZ) / 1000) + 1)
// Longest time from shutdown notice to power off, in ms.
`define MPRS_OFF_MS 1000
`define MPRS_OFF_CYC ((`MPRS_OFF_MS * `MPRS_CLK_HZ) / 1000)

`endif

// ### pkg/mprs_pkg.sv
// Types shared by the power-up and restart sequencer.
package mprs_pkg;

    // Top-level sequencing states.
    typedef enum logic [3:0] {
        MPRS_OFF,
        MPRS_RISE,
        MPRS_SLOW_WAIT,
        MPRS_BLIP,
        MPRS_RESET,
        MPRS_INIT,
        MPRS_NORMAL,
        MPRS_ALARM,
        MPRS_SHUTDOWN
    } mprs_state_t;

    // Firmware-side requests.
    typedef struct packed {
        logic shutdown_command;
        logic restart_command;
        logic functionality_command;
        logic init_done;
    } mprs_fw_req_t;

    // Notices and mode flags reported back.
    typedef struct packed {
        logic startup_ready_notice;
        logic alarm_mode_notice;
        logic shutdown_notice;
    } mprs_notice_t;

endpackage

// ### rtl/mprs_pulse_filter.sv
// Low-width qualifier for the emergency reset input.
`timescale 1ns/1ps
module mprs_pulse_filter
    import mprs_pkg::*;
#(
    parameter int unsigned MIN_CYC = 250001,
    parameter int unsigned CW = 20
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic line_n_i,
    output logic held_low_o,
    output logic rise_o
);

    logic sync1_ff;
    logic sync2_ff;
    logic last_ff;
    logic [CW-1:0] cnt_ff;
    logic held_ff;

    // ************************************************************
    // Two-stage synchroniser; stage one feeds stage two only.
    // ************************************************************
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            last_ff <= 1'b1;
        end else if (enable_i) begin
            sync1_ff <= line_n_i;
            sync2_ff <= sync1_ff;
            last_ff <= sync2_ff;
        end
    end

    // Count continuous low time; a high sample restarts the count.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_ff <= '0;
            held_ff <= 1'b0;
        end else if (enable_i) begin
            if (sync2_ff) begin
                cnt_ff <= '0;
                held_ff <= 1'b0;
            end else if (cnt_ff >= CW'(MIN_CYC - 1)) begin
                held_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
    end

    assign held_low_o = held_ff;
    // Release edge counts only after a qualified low, so spikes do nothing.
    assign rise_o = held_ff & sync2_ff & ~last_ff;

endmodule // mprs_pulse_filter

// ### rtl/mprs_sequencer.sv
// Power-up, restart and emergency reset sequencer of the modem module.
`timescale 1ns/1ps
`include "mprs_defines.svh"
module mprs_sequencer
    import mprs_pkg::*;
#(
    parameter int unsigned SLOW_RISE_CYC = `MPRS_SLOW_RISE_CYC,
    parameter int unsigned SLOW_DELAY_CYC = `MPRS_SLOW_DELAY_CYC,
    parameter int unsigned BLIP_CYC = `MPRS_BLIP_CYC,
    parameter int unsigned ERST_CYC = `MPRS_ERST_CYC,
    parameter int unsigned OFF_CYC = `MPRS_OFF_CYC,
    parameter int unsigned CW = 25
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic main_supply_i,
    input wire logic supply_good_i,
    input wire logic power_on_i,
    input wire logic emergency_reset_n_i,
    input wire logic rtc_alarm_i,
    input wire logic autobaud_i,
    input wire logic flow_rtscts_i,
    input wire mprs_fw_req_t fw_req_i,
    output mprs_state_t state_o,
    output mprs_notice_t notice_o,
    output logic regulators_on_o,
    output logic rtc_backup_supply_o,
    output logic cpu_reset_o,
    output logic pads_reset_o,
    output logic volatile_clear_o,
    output logic fw_init_o,
    output logic primary_clear_to_send_o,
    output logic primary_set_ready_o,
    output logic secondary_clear_to_send_o,
    output logic registered_allowed_o,
    output logic pin_required_o,
    output logic limited_commands_o,
    output logic flow_handshake_o
);

    mprs_state_t state_ff;
    mprs_state_t nxt_state;
    logic [CW-1:0] timer_ff;
    logic [CW-1:0] nxt_timer;
    logic supply_last_ff;
    logic pon_last_ff;
    logic alarm_pending_ff;
    logic from_alarm_ff;
    logic pin_req_ff;
    logic ready_ff;
    mprs_notice_t notice_ff;
    logic erst_held;
    logic erst_rise;
    logic supply_rise;
    logic pon_edge;
    logic timer_done;

    // ************************************************************
    // Emergency reset qualification.
    // ************************************************************
    mprs_pulse_filter #(
        .MIN_CYC(ERST_CYC),
        .CW(CW)
    ) u_erst (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .enable_i(clk_en_i),
        .line_n_i(emergency_reset_n_i),
        .held_low_o(erst_held),
        .rise_o(erst_rise)
    );

    // ************************************************************
    // Edge detection on supply and power-on request.
    // ************************************************************

    // Previous samples; held low at reset so a level present at start
    // shows up as an edge once the clock runs.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            supply_last_ff <= 1'b0;
            pon_last_ff <= 1'b0;
        end else if (clk_en_i) begin
            supply_last_ff <= main_supply_i;
            pon_last_ff <= power_on_i;
        end
    end

    assign supply_rise = main_supply_i & ~supply_last_ff;
    // A single sampled high is enough; glitch filtering is the host's job.
    assign pon_edge = power_on_i & ~pon_last_ff;
    assign timer_done = (timer_ff == '0);

    // ************************************************************
    // Main sequencing state machine.
    // ************************************************************

    // Next state and timer load; one timer serves every timed phase.
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_done ? timer_ff : timer_ff - CW'(1);
        case (state_ff)
            MPRS_OFF: begin
                if (supply_rise) begin
                    nxt_state = MPRS_RISE;
                    nxt_timer = CW'(SLOW_RISE_CYC);
                end else if (main_supply_i && rtc_alarm_i &&
                             alarm_pending_ff) begin
                    nxt_state = MPRS_RESET;
                end else if (main_supply_i && pon_edge) begin
                    nxt_state = MPRS_RESET;
                end
            end
            MPRS_RISE: begin
                if (supply_good_i) begin
                    if (!power_on_i) begin
                        nxt_state = MPRS_BLIP;
                        nxt_timer = CW'(BLIP_CYC);
                    end else if (timer_done) begin
                        nxt_state = MPRS_SLOW_WAIT;
                        nxt_timer = CW'(SLOW_DELAY_CYC);
                    end else begin
                        nxt_state = MPRS_RESET;
                    end
                end
            end
            MPRS_SLOW_WAIT: begin
                if (timer_done) begin
                    nxt_state = MPRS_RESET;
                end
            end
            MPRS_BLIP: begin
                if (timer_done) begin
                    nxt_state = MPRS_OFF;
                end
            end
            MPRS_RESET: begin
                // Leave on the release edge, or at once if nothing is held.
                if (erst_rise) begin
                    nxt_state = MPRS_INIT;
                end else if (!erst_held) begin
                    nxt_state = MPRS_INIT;
                end
            end
            MPRS_INIT: begin
                if (fw_req_i.init_done) begin
                    nxt_state = from_alarm_ff ? MPRS_ALARM : MPRS_NORMAL;
                end
            end
            MPRS_NORMAL: begin
                if (fw_req_i.restart_command) begin
                    nxt_state = MPRS_RESET;
                end else if (fw_req_i.shutdown_command) begin
                    nxt_state = MPRS_SHUTDOWN;
                    nxt_timer = CW'(OFF_CYC);
                end
            end
            MPRS_ALARM: begin
                if (fw_req_i.functionality_command || pon_edge) begin
                    nxt_state = MPRS_NORMAL;
                end else if (fw_req_i.shutdown_command) begin
                    nxt_state = MPRS_SHUTDOWN;
                    nxt_timer = CW'(OFF_CYC);
                end
            end
            MPRS_SHUTDOWN: begin
                if (timer_done) begin
                    // A power-on request still high turns this into a restart.
                    nxt_state = power_on_i ? MPRS_RESET : MPRS_OFF;
                end
            end
            default: begin
                nxt_state = MPRS_OFF;
            end
        endcase
        // Supply loss drops everything; qualified emergency reset wins next, except in MPRS_OFF, MPRS_BLIP and on the release edge in MPRS_RESET.
        if (!main_supply_i) begin
            nxt_state = MPRS_OFF;
        end else if (erst_held && state_ff != MPRS_OFF &&
                     state_ff != MPRS_BLIP &&
                     !(state_ff == MPRS_RESET && erst_rise)) begin
            nxt_state = MPRS_RESET;
        end
    end

    // State and timer registers.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= MPRS_OFF;
            timer_ff <= '0;
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
        end
    end

    // ************************************************************
    // Alarm bookkeeping and restart memory.
    // ************************************************************

    // The armed alarm lives in the RTC domain and survives a shutdown.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            alarm_pending_ff <= 1'b1;
            from_alarm_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (state_ff == MPRS_OFF && nxt_state == MPRS_RESET) begin
                from_alarm_ff <= rtc_alarm_i & alarm_pending_ff;
            end else if (nxt_state == MPRS_RESET && state_ff != MPRS_OFF) begin
                from_alarm_ff <= 1'b0;
            end
            if (!main_supply_i) begin
                alarm_pending_ff <= 1'b1;
            end else if (state_ff == MPRS_ALARM) begin
                alarm_pending_ff <= 1'b0;
            end else if (state_ff == MPRS_SHUTDOWN) begin
                alarm_pending_ff <= 1'b1;
            end
        end
    end

    // SIM PIN must be entered again after each restart.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_req_ff <= 1'b1;
        end else if (clk_en_i) begin
            if (state_ff == MPRS_RESET) begin
                pin_req_ff <= 1'b1;
            end else if (state_ff == MPRS_NORMAL) begin
                pin_req_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Notices and readiness lines.
    // ************************************************************

    // One-cycle notices; both startup notices are muted by autobauding.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            notice_ff <= '0;
            ready_ff <= 1'b0;
        end else if (clk_en_i) begin
            notice_ff.startup_ready_notice <= ~autobaud_i &
                (state_ff == MPRS_INIT) & (nxt_state == MPRS_NORMAL);
            notice_ff.alarm_mode_notice <= ~autobaud_i &
                (state_ff == MPRS_INIT) & (nxt_state == MPRS_ALARM);
            notice_ff.shutdown_notice <= (state_ff != MPRS_SHUTDOWN) &
                (nxt_state == MPRS_SHUTDOWN);
            ready_ff <= (nxt_state == MPRS_NORMAL) ||
                (nxt_state == MPRS_ALARM);
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign state_o = state_ff;
    assign notice_o = notice_ff;
    assign regulators_on_o = (state_ff != MPRS_OFF);
    // The RTC keeps running from the backup rail as long as supply exists.
    assign rtc_backup_supply_o = main_supply_i;
    assign cpu_reset_o = (state_ff == MPRS_RESET) | erst_held;
    assign pads_reset_o = (state_ff == MPRS_RESET) | erst_held |
        (state_ff == MPRS_OFF);
    assign volatile_clear_o = erst_held;
    assign fw_init_o = (state_ff == MPRS_INIT);
    // Lines sit high through init and go low when it completes.
    assign primary_clear_to_send_o = ~ready_ff;
    assign primary_set_ready_o = ~ready_ff;
    assign secondary_clear_to_send_o = ~ready_ff;
    assign registered_allowed_o = (state_ff == MPRS_NORMAL) &
        ~pin_req_ff;
    assign pin_required_o = pin_req_ff;
    assign limited_commands_o = (state_ff == MPRS_ALARM);
    // Handshaking stays off until the host selects it.
    assign flow_handshake_o = flow_rtscts_i;

endmodule // mprs_sequencer

// ### verif/mprs_checker.sv
// Port-level assertions for the power-up and restart sequencer.
`timescale 1ns/1ps
module mprs_checker
    import mprs_pkg::*;
#(
    parameter int unsigned ERST_CYC = 250001,
    parameter int unsigned OFF_CYC = 25000000
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic main_supply_i,
    input wire logic supply_good_i,
    input wire logic power_on_i,
    input wire logic emergency_reset_n_i,
    input wire logic autobaud_i,
    input wire mprs_fw_req_t fw_req_i,
    input wire mprs_state_t state_o,
    input wire mprs_notice_t notice_o,
    input wire logic cpu_reset_o,
    input wire logic volatile_clear_o,
    input wire logic primary_clear_to_send_o,
    input wire logic primary_set_ready_o,
    input wire logic secondary_clear_to_send_o,
    input wire logic pin_required_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    logic [7:0] low_cnt_ff;
    logic [31:0] off_cnt_ff;
    logic go;

    // Low-run length saturates, so a very long pull cannot wrap to zero.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) low_cnt_ff <= 8'h00;
        else if (emergency_reset_n_i) low_cnt_ff <= 8'h00;
        else if (low_cnt_ff != 8'hFF) low_cnt_ff <= low_cnt_ff + 8'h01;
    end
    // Cycles spent in shutdown so far.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) off_cnt_ff <= 32'h0;
        else if (state_o == MPRS_SHUTDOWN) off_cnt_ff <= off_cnt_ff + 32'h1;
        else off_cnt_ff <= 32'h0;
    end
    // Requests only count on enabled edges with the supply present.
    assign go = clk_en_i && main_supply_i;

    auto_on_a: assert property (
        go && state_o == MPRS_RISE && supply_good_i && power_on_i
        |=> state_o inside {MPRS_RESET, MPRS_SLOW_WAIT}) else $error("no start");
    edge_start_a: assert property (
        go && $past(main_supply_i) && state_o == MPRS_OFF && $rose(power_on_i)
        |=> state_o == MPRS_RESET) else $error("edge ignored");
    restart_pin_a: assert property (
        go && state_o == MPRS_NORMAL && fw_req_i.restart_command
        |=> state_o == MPRS_RESET ##2 pin_required_o) else $error("restart");
    shutdown_note_a: assert property (
        go && state_o == MPRS_NORMAL && fw_req_i.shutdown_command
        && !fw_req_i.restart_command
        |=> notice_o.shutdown_notice) else $error("no shutdown notice");
    off_budget_a: assert property (
        state_o == MPRS_SHUTDOWN |-> off_cnt_ff <= OFF_CYC)
        else $error("shutdown too long");
    erst_hold_a: assert property (
        low_cnt_ff >= ERST_CYC + 4 |-> cpu_reset_o && volatile_clear_o)
        else $error("long pull ignored");
    erst_short_a: assert property (
        $rose(emergency_reset_n_i) && low_cnt_ff < ERST_CYC && !volatile_clear_o
        |=> !volatile_clear_o [*4]) else $error("short pull taken");
    ready_lines_a: assert property (
        state_o == MPRS_NORMAL |-> !primary_clear_to_send_o
        && !primary_set_ready_o && !secondary_clear_to_send_o)
        else $error("ready lines high");
    notice_a: assert property (
        go && state_o == MPRS_INIT && fw_req_i.init_done && emergency_reset_n_i
        |=> notice_o.startup_ready_notice == (state_o == MPRS_NORMAL && !autobaud_i)
        && notice_o.alarm_mode_notice == (state_o == MPRS_ALARM && !autobaud_i))
        else $error("wrong notice");
endmodule // mprs_checker

bind mprs_sequencer mprs_checker #(.ERST_CYC(ERST_CYC), .OFF_CYC(OFF_CYC)) chk (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .main_supply_i(main_supply_i), .supply_good_i(supply_good_i),
    .power_on_i(power_on_i), .emergency_reset_n_i(emergency_reset_n_i),
    .autobaud_i(autobaud_i), .fw_req_i(fw_req_i), .state_o(state_o),
    .notice_o(notice_o), .cpu_reset_o(cpu_reset_o),
    .volatile_clear_o(volatile_clear_o),
    .primary_clear_to_send_o(primary_clear_to_send_o),
    .primary_set_ready_o(primary_set_ready_o),
    .secondary_clear_to_send_o(secondary_clear_to_send_o),
    .pin_required_o(pin_required_o));

// ### verif/mprs_host.sv
// Host processor model driving power-on and the emergency reset pull.
`timescale 1ns/1ps
module mprs_host (
    input wire logic core_clk_i,
    input wire logic on_req_i,
    input wire logic pull_req_i,
    input wire logic clear_to_send_i,
    output logic power_on_o,
    output logic reset_pull_o,
    output logic may_send_o
);
    // Lines start idle so the device never sees an unknown at power-up.
    initial begin
        power_on_o = 1'h0;
        reset_pull_o = 1'h0;
        may_send_o = 1'h0;
    end
    // Registered outputs cannot glitch; pulls happen only when ordered and
    // only low, the bench pull-up supplies the high level.
    always @(posedge core_clk_i) begin
        power_on_o <= on_req_i;
        reset_pull_o <= pull_req_i;
        may_send_o <= !clear_to_send_i;
    end
endmodule // mprs_host

// ### verif/tb.sv
// Self-checking bench for the power-up and restart sequencer.
`timescale 1ns/1ps
module tb;
    import mprs_pkg::*;
    // A power-up case: request, good delay, autobaud, state, notice.
    typedef struct packed {
        logic pon;
        logic [7:0] dly;
        logic ab;
        mprs_state_t st;
        logic [3:0] note;
    } mprs_row_t;
    mprs_row_t rows [4] = '{'{1'h1, 8'h02, 1'h0, MPRS_RESET, 4'h1},
        '{1'h1, 8'h02, 1'h1, MPRS_RESET, 4'h0},
        '{1'h0, 8'h02, 1'h0, MPRS_BLIP, 4'h0},
        '{1'h1, 8'h0C, 1'h0, MPRS_SLOW_WAIT, 4'h1}};
    logic core_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic clk_en_i = 1'h1;
    logic main_supply_i = 1'h0;
    logic supply_good_i = 1'h0;
    logic rtc_alarm_i = 1'h0;
    logic autobaud_i = 1'h0;
    logic on_req = 1'h0;
    logic pull_req = 1'h0;
    mprs_fw_req_t fw_req_i = '0;
    mprs_state_t state_o;
    mprs_notice_t notice_o;
    logic power_on, pull, may_send, erst_n, regs_on, cpu_rst, vol_clr;
    logic primary_clear_to_send, pin_req, limited, flow_hs;
    logic primary_set_ready, secondary_clear_to_send, pads_rst, reg_ok;
    logic flow_sel = 1'h0;
    int miscompares = 0;
    int checks_done = 0;

    // Open-drain reset line with its pull-up.
    assign erst_n = pull ? 1'h0 : 1'h1;
    always #20 core_clk_i = ~core_clk_i;

    // Short counts keep the run brief; expectations follow them.
    mprs_sequencer #(.SLOW_RISE_CYC(8), .SLOW_DELAY_CYC(20), .BLIP_CYC(10),
        .ERST_CYC(5), .OFF_CYC(10)) uut (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .clk_en_i(clk_en_i), .main_supply_i(main_supply_i),
        .supply_good_i(supply_good_i), .power_on_i(power_on),
        .emergency_reset_n_i(erst_n), .rtc_alarm_i(rtc_alarm_i),
        .autobaud_i(autobaud_i), .flow_rtscts_i(flow_sel), .fw_req_i(fw_req_i),
        .state_o(state_o), .notice_o(notice_o), .regulators_on_o(regs_on),
        .rtc_backup_supply_o(), .cpu_reset_o(cpu_rst),
        .pads_reset_o(pads_rst), .volatile_clear_o(vol_clr), .fw_init_o(),
        .primary_clear_to_send_o(primary_clear_to_send), .primary_set_ready_o(primary_set_ready),
        .secondary_clear_to_send_o(secondary_clear_to_send), .registered_allowed_o(reg_ok),
        .pin_required_o(pin_req),
        .limited_commands_o(limited), .flow_handshake_o(flow_hs));
    mprs_host host (.core_clk_i(core_clk_i), .on_req_i(on_req),
        .pull_req_i(pull_req), .clear_to_send_i(primary_clear_to_send), .power_on_o(power_on),
        .reset_pull_o(pull), .may_send_o(may_send));

    task automatic check(input string nm, input logic [3:0] seen,
            input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Polls at falling edges, where outputs have settled; gives up at lim.
    task automatic wait_state(input mprs_state_t s, input int lim);
        int n;
        n = 0;
        @(negedge core_clk_i);
        while (state_o !== s && n < lim) begin
            @(negedge core_clk_i);
            n++;
        end
        check("state", state_o, s);
        if (state_o !== s) print_verdict();
    endtask
    task automatic fw_pulse(input mprs_fw_req_t r);
        @(posedge core_clk_i);
        fw_req_i <= r;
        @(posedge core_clk_i);
        fw_req_i <= '0;
    endtask
    task automatic init_ok(input mprs_state_t s);
        wait_state(MPRS_INIT, 40);
        fw_pulse(4'h1);
        wait_state(s, 3);
    endtask
    task automatic shut(input mprs_state_t s);
        fw_pulse(4'h8);
        wait_state(MPRS_SHUTDOWN, 3);
        check("off notice", notice_o.shutdown_notice, 4'h1);
        wait_state(s, 15);
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'h0;
        check("flow", flow_hs, 4'h0);
        flow_sel <= 1'h1;
        foreach (rows[i]) begin
            @(posedge core_clk_i);
            main_supply_i <= 1'h0;
            supply_good_i <= 1'h0;
            on_req <= rows[i].pon;
            autobaud_i <= rows[i].ab;
            repeat (3) @(posedge core_clk_i);
            main_supply_i <= 1'h1;
            repeat (rows[i].dly) @(posedge core_clk_i);
            supply_good_i <= 1'h1;
            wait_state(rows[i].st, 30);
            if (rows[i].st == MPRS_BLIP) wait_state(MPRS_OFF, 15);
            else init_ok(MPRS_NORMAL);
            check("ready", notice_o.startup_ready_notice, rows[i].note);
        end
        check("flow", flow_hs, 4'h1);
        // A request while the clock enable is low must be lost.
        @(posedge core_clk_i);
        clk_en_i <= 1'h0;
        fw_pulse(4'h4);
        wait_state(MPRS_NORMAL, 0);
        @(posedge core_clk_i);
        clk_en_i <= 1'h1;
        fw_pulse(4'h4);
        wait_state(MPRS_RESET, 3);
        @(negedge core_clk_i);
        check("pin", pin_req, 4'h1);
        init_ok(MPRS_NORMAL);
        @(negedge core_clk_i);
        check("pin", pin_req, 4'h0);
        check("registered", reg_ok, 4'h1);
        check("dsr", primary_set_ready, 4'h0);
        check("secondary_clear_to_send", secondary_clear_to_send, 4'h0);
        shut(MPRS_RESET);
        init_ok(MPRS_NORMAL);
        @(posedge core_clk_i);
        on_req <= 1'h0;
        shut(MPRS_OFF);
        check("regs", regs_on, 4'h0);
        check("pads", pads_rst, 4'h1);
        // One-cycle request pulse, then wake by the alarm.
        @(posedge core_clk_i);
        on_req <= 1'h1;
        @(posedge core_clk_i);
        on_req <= 1'h0;
        wait_state(MPRS_RESET, 5);
        init_ok(MPRS_NORMAL);
        shut(MPRS_OFF);
        @(posedge core_clk_i);
        rtc_alarm_i <= 1'h1;
        wait_state(MPRS_RESET, 5);
        @(posedge core_clk_i);
        rtc_alarm_i <= 1'h0;
        init_ok(MPRS_ALARM);
        check("alarm", notice_o.alarm_mode_notice, 4'h1);
        check("limit", limited, 4'h1);
        check("registered", reg_ok, 4'h0);
        fw_pulse(4'h2);
        wait_state(MPRS_NORMAL, 3);
        // Short pull is ignored, a long one resets and restarts.
        @(posedge core_clk_i);
        pull_req <= 1'h1;
        repeat (3) @(posedge core_clk_i);
        pull_req <= 1'h0;
        repeat (12) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check("clear", vol_clr, 4'h0);
        @(posedge core_clk_i);
        pull_req <= 1'h1;
        wait_state(MPRS_RESET, 15);
        check("cpu", cpu_rst, 4'h1);
        check("clear", vol_clr, 4'h1);
        check("pads", pads_rst, 4'h1);
        @(posedge core_clk_i);
        pull_req <= 1'h0;
        init_ok(MPRS_NORMAL);
        repeat (2) @(negedge core_clk_i);
        check("send", may_send, 4'h1);
        @(posedge core_clk_i);
        reset_i <= 1'h1;
        wait_state(MPRS_OFF, 1);
        check("cts", primary_clear_to_send, 4'h1);
        check("dsr", primary_set_ready, 4'h1);
        check("secondary_clear_to_send", secondary_clear_to_send, 4'h1);
        print_verdict();
    end
    // Hang guard.
    initial begin
        repeat (4000) @(posedge core_clk_i);
        miscompares++;
        $display("Error run expected end seen timeout");
        print_verdict();
    end
endmodule // tb
